// *** src/dmad_regs.svh ***
// region boundaries and widths for the default memory attribute decoder
`ifndef DMAD_REGS_SVH
`define DMAD_REGS_SVH
// ----------------------------------------
// region boundaries
// ----------------------------------------
`define DMAD_CODE_BASE    32'h0000_0000
`define DMAD_CODE_END     32'h1FFF_FFFF
`define DMAD_SRAM_BASE    32'h2000_0000
`define DMAD_SRAM_END     32'h3FFF_FFFF
`define DMAD_PERIPH_BASE  32'h4000_0000
`define DMAD_PERIPH_END   32'h5FFF_FFFF
`define DMAD_RAM_BASE     32'h6000_0000
`define DMAD_RAM_END      32'h9FFF_FFFF
`define DMAD_EXTDEV_BASE  32'hA000_0000
`define DMAD_EXTDEV_END   32'hDFFF_FFFF
`define DMAD_PPB_BASE     32'hE000_0000
`define DMAD_PPB_END      32'hE003_FFFF
`define DMAD_DEBUG_BASE   32'hE004_0000
`define DMAD_DEBUG_END    32'hE004_3FFF
`define DMAD_ROMTAB_BASE  32'hE004_4000
`define DMAD_ROMTAB_END   32'hE00F_FFFF
`define DMAD_VENDOR_BASE  32'hE010_0000
`define DMAD_VENDOR_END   32'hFFFF_FFFF
// ----------------------------------------
// widths
// ----------------------------------------
`define DMAD_ADDR_W       32
`endif

// *** src/dmad_pkg.sv ***
// types shared by the default memory attribute decoder
package dmad_pkg;
   // ----------------------------------------
   // enumerations
   // ----------------------------------------
   typedef enum logic [3:0] {
      DMAD_RGN_CODE,
      DMAD_RGN_SRAM,
      DMAD_RGN_PERIPH,
      DMAD_RGN_RAM,
      DMAD_RGN_EXTDEV,
      DMAD_RGN_PPB,
      DMAD_RGN_DEBUG,
      DMAD_RGN_ROMTAB,
      DMAD_RGN_VENDOR
   } dmad_region_t;

   typedef enum logic [1:0] {
      DMAD_MEM_NORMAL,
      DMAD_MEM_STRICT_DEVICE_ORDER,
      DMAD_MEM_DEVICE_EARLY_ACK
   } dmad_mem_t;

   typedef enum logic [1:0] {
      DMAD_ATTR_NONSECURE,
      DMAD_ATTR_SECURE,
      DMAD_ATTR_NONSECURE_CALLABLE
   } dmad_sec_t;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      dmad_region_t region;
      dmad_mem_t mem_type;
      logic shareable;
      logic execute_never;
      logic cacheable;
   } dmad_attr_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic is_fetch;
      logic is_write;
      logic ordered;
      logic secure_state;
      logic secure_gateway_instr;
   } dmad_req_t;

   typedef struct packed {
      logic hit;
      dmad_mem_t mem_type;
      logic shareable;
      logic execute_never;
      logic cacheable;
   } dmad_mpu_t;

   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic is_write;
      logic nonsecure;
      logic device;
      logic early_ack;
      logic shareable;
      logic cacheable;
      logic allocate;
      logic mergeable;
   } dmad_bus_t;

   typedef struct packed {
      logic security_violation;
      logic mem_mgmt_fault;
      logic gateway_entry;
   } dmad_fault_t;
endpackage : dmad_pkg

// *** src/dmad_region_map.sv ***
// address to default region attributes lookup
`include "dmad_regs.svh"
module dmad_region_map (
   input wire logic [31:0] i_addr,
   output dmad_pkg::dmad_attr_t o_attr
);
   import dmad_pkg::*;

   // ----------------------------------------
   // range test
   // ----------------------------------------
   function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic dmad_attr_t mk(input dmad_region_t r, input dmad_mem_t m);
      dmad_attr_t t;
      t.region = r;
      t.mem_type = m;
      t.shareable = (m != DMAD_MEM_NORMAL);
      t.execute_never = (m != DMAD_MEM_NORMAL);
      t.cacheable = (m == DMAD_MEM_NORMAL);
      mk = t;
   endfunction : mk

   // ----------------------------------------
   // decode
   // ----------------------------------------
   always_comb begin
      if (in_range(i_addr, `DMAD_CODE_BASE, `DMAD_CODE_END)) begin
         o_attr = mk(DMAD_RGN_CODE, DMAD_MEM_NORMAL);
      end else if (in_range(i_addr, `DMAD_SRAM_BASE, `DMAD_SRAM_END)) begin
         o_attr = mk(DMAD_RGN_SRAM, DMAD_MEM_NORMAL);
      end else if (in_range(i_addr, `DMAD_PERIPH_BASE, `DMAD_PERIPH_END)) begin
         o_attr = mk(DMAD_RGN_PERIPH, DMAD_MEM_DEVICE_EARLY_ACK);
      end else if (in_range(i_addr, `DMAD_RAM_BASE, `DMAD_RAM_END)) begin
         o_attr = mk(DMAD_RGN_RAM, DMAD_MEM_NORMAL);
      end else if (in_range(i_addr, `DMAD_EXTDEV_BASE, `DMAD_EXTDEV_END)) begin
         o_attr = mk(DMAD_RGN_EXTDEV, DMAD_MEM_DEVICE_EARLY_ACK);
      end else if (in_range(i_addr, `DMAD_PPB_BASE, `DMAD_PPB_END)) begin
         o_attr = mk(DMAD_RGN_PPB, DMAD_MEM_STRICT_DEVICE_ORDER);
      end else if (in_range(i_addr, `DMAD_DEBUG_BASE, `DMAD_DEBUG_END)) begin
         o_attr = mk(DMAD_RGN_DEBUG, DMAD_MEM_STRICT_DEVICE_ORDER);
      end else if (in_range(i_addr, `DMAD_ROMTAB_BASE, `DMAD_ROMTAB_END)) begin
         o_attr = mk(DMAD_RGN_ROMTAB, DMAD_MEM_STRICT_DEVICE_ORDER);
      end else begin
         o_attr = mk(DMAD_RGN_VENDOR, DMAD_MEM_DEVICE_EARLY_ACK);
      end
   end
endmodule : dmad_region_map

// *** src/dmad_decoder.sv ***
// default memory attribute decoder top: attributes, security marking, mpu bank select
//
// What this block does
// - only strict-order or early-ack device sub-types are ever produced.
// - gathering never merges across barriers or acquire/release accesses.
// - attribution units together classify every address as secure or non-secure.
// - an access to a secure address is marked secure on the bus.
// - non-secure access to secure address is blocked and raises an exception.
// - secure gateway instruction counts only when fetched from non-secure-callable memory.
// - access to a non-secure address goes out non-secure, whoever issued it.
// - fetches pick the mpu bank from the address attribution.
// - loads and stores pick the mpu bank from current security state.
// - 0x00000000-0x1FFFFFFF is code: normal, non-shareable, executable.
// - 0x20000000-0x3FFFFFFF is sram: normal, non-shareable, executable.
// - 0x60000000-0x9FFFFFFF is ram: normal, executable; only these three hold programs.
// - 0xE0000000-0xE003FFFF is private peripheral bus, strict-order device, execute-never.
// - 0xE0040000-0xE0043FFF is debug device, strict-order, shareable, execute-never.
// - 0xE0044000-0xE00FFFFF holds rom tables, strict-order device, execute-never.
// - an enabled matching mpu region overrides the default attributes.
// - fetch from execute-never memory raises a memory management fault, unless it is blocked as a security violation.
// - device and normal accesses alike stay in issue order.
`include "dmad_regs.svh"
module dmad_decoder (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input dmad_pkg::dmad_req_t i_req,
   input wire logic i_security_ext,
   input wire logic i_sau_hit,
   input dmad_pkg::dmad_sec_t i_sau_attr,
   input dmad_pkg::dmad_sec_t i_fixed_attr,
   input dmad_pkg::dmad_mpu_t i_mpu_secure,
   input dmad_pkg::dmad_mpu_t i_mpu_nonsecure,
   input wire logic i_bus_ready,
   output wire logic o_req_ready,
   output dmad_pkg::dmad_attr_t o_attr,
   output dmad_pkg::dmad_sec_t o_attr_sec,
   output logic o_mpu_bank_secure,
   output dmad_pkg::dmad_bus_t o_bus,
   output dmad_pkg::dmad_fault_t o_fault
);
   import dmad_pkg::*;

   // ----------------------------------------
   // default region lookup
   // ----------------------------------------
   dmad_attr_t dflt;
   dmad_region_map u_map (
      .i_addr(i_req.addr),
      .o_attr(dflt)
   );

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // the more secure of two attributions wins, so no address is ever left unclassified
   function automatic dmad_sec_t combine_sec(input logic ext, input logic sau_hit, input dmad_sec_t security_attribution_unit,
                                             input dmad_sec_t fixed);
      dmad_sec_t s;
      if (!ext) begin
         s = DMAD_ATTR_NONSECURE;
      end else if (!sau_hit) begin
         s = DMAD_ATTR_SECURE;
      end else if (fixed == DMAD_ATTR_SECURE || security_attribution_unit == DMAD_ATTR_SECURE) begin
         s = DMAD_ATTR_SECURE;
      end else if (fixed == DMAD_ATTR_NONSECURE_CALLABLE || security_attribution_unit == DMAD_ATTR_NONSECURE_CALLABLE) begin
         s = DMAD_ATTR_NONSECURE_CALLABLE;
      end else begin
         s = DMAD_ATTR_NONSECURE;
      end
      combine_sec = s;
   endfunction : combine_sec

   function automatic logic is_device(input dmad_mem_t m);
      is_device = (m != DMAD_MEM_NORMAL);
   endfunction : is_device

   // ----------------------------------------
   // attribution and bank selection
   // ----------------------------------------
   dmad_sec_t sec;
   logic addr_secure;
   logic bank_secure;
   dmad_mpu_t mpu;
   dmad_attr_t eff;
   logic blocked;
   logic xn_fault;
   logic sg_entry;

   always_comb begin
      sec = combine_sec(i_security_ext, i_sau_hit, i_sau_attr, i_fixed_attr);
      addr_secure = (sec != DMAD_ATTR_NONSECURE);
      if (i_req.is_fetch) begin
         bank_secure = addr_secure;
      end else begin
         bank_secure = i_req.secure_state;
      end
      mpu = bank_secure ? i_mpu_secure : i_mpu_nonsecure;
      eff = dflt;
      if (mpu.hit) begin
         eff.mem_type = mpu.mem_type;
         eff.shareable = mpu.shareable;
         eff.execute_never = mpu.execute_never;
         eff.cacheable = mpu.cacheable;
      end
      if (is_device(eff.mem_type)) begin
         eff.shareable = 1'b1;
         eff.cacheable = 1'b0;
         eff.execute_never = 1'b1;
      end
      sg_entry = i_req.is_fetch && i_req.secure_gateway_instr && !i_req.secure_state
                 && (sec == DMAD_ATTR_NONSECURE_CALLABLE);
      // a gateway fetch from non-secure-callable memory is the one legal way in, so it is not blocked
      blocked = i_security_ext && !i_req.secure_state && addr_secure && !sg_entry;
      xn_fault = i_req.is_fetch && eff.execute_never;
   end

   // ----------------------------------------
   // pipeline register toward the bus
   // ----------------------------------------
   // one stage only; device ordering is kept because requests leave in issue order
   dmad_bus_t bus_r, bus_nxt;
   dmad_fault_t fault_r, fault_nxt;
   dmad_attr_t attr_r, attr_nxt;
   dmad_sec_t sec_r, sec_nxt;
   logic bank_r, bank_nxt;
   logic stall;

   assign stall = bus_r.valid && !i_bus_ready;
   assign o_req_ready = !stall;

   always_comb begin
      bus_nxt = bus_r;
      fault_nxt = fault_r;
      attr_nxt = attr_r;
      sec_nxt = sec_r;
      bank_nxt = bank_r;
      if (!stall) begin
         bus_nxt = '0;
         fault_nxt = '0;
         if (i_req.valid) begin
            attr_nxt = eff;
            sec_nxt = sec;
            bank_nxt = bank_secure;
            fault_nxt.security_violation = blocked;
            fault_nxt.mem_mgmt_fault = xn_fault && !blocked;
            fault_nxt.gateway_entry = sg_entry;
            if (!blocked && !xn_fault) begin
               bus_nxt.valid = 1'b1;
               bus_nxt.addr = i_req.addr;
               bus_nxt.is_write = i_req.is_write;
               bus_nxt.nonsecure = !addr_secure;
               bus_nxt.device = is_device(eff.mem_type);
               bus_nxt.early_ack = (eff.mem_type == DMAD_MEM_DEVICE_EARLY_ACK);
               bus_nxt.shareable = eff.shareable;
               bus_nxt.cacheable = eff.cacheable;
               bus_nxt.allocate = eff.cacheable;
               // only sub-types are non-gathering, so nothing merges; ordered ops never merge
               bus_nxt.mergeable = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         bus_r <= '0;
         fault_r <= '0;
         attr_r <= '0;
         sec_r <= DMAD_ATTR_SECURE;
         bank_r <= 1'b1;
      end else if (i_clk_en) begin
         bus_r <= bus_nxt;
         fault_r <= fault_nxt;
         attr_r <= attr_nxt;
         sec_r <= sec_nxt;
         bank_r <= bank_nxt;
      end
   end

   assign o_bus = bus_r;
   assign o_fault = fault_r;
   assign o_attr = attr_r;
   assign o_attr_sec = sec_r;
   assign o_mpu_bank_secure = bank_r;
endmodule : dmad_decoder

// *** tb/dmad_decoder_monitor.sv ***
// port assertions for the default memory attribute decoder
module dmad_decoder_monitor (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input dmad_pkg::dmad_req_t i_req,
   input wire logic i_security_ext,
   input wire logic i_sau_hit,
   input dmad_pkg::dmad_sec_t i_sau_attr,
   input dmad_pkg::dmad_sec_t i_fixed_attr,
   input dmad_pkg::dmad_mpu_t i_mpu_secure,
   input dmad_pkg::dmad_mpu_t i_mpu_nonsecure,
   input wire logic i_bus_ready,
   input wire logic o_req_ready,
   input dmad_pkg::dmad_attr_t o_attr,
   input dmad_pkg::dmad_sec_t o_attr_sec,
   input wire logic o_mpu_bank_secure,
   input dmad_pkg::dmad_bus_t o_bus,
   input dmad_pkg::dmad_fault_t o_fault
);
   timeunit 1ns;
   timeprecision 1ns;
   import dmad_pkg::*;
   logic tk;
   assign tk = i_clk_en && i_req.valid && o_req_ready;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // ----------------------------------------
   // attributes and marking
   // ----------------------------------------
   a_two_subtypes: assert property (o_attr.mem_type != dmad_mem_t'(2'h3))
      else $error("memory type outside the two device sub-types");
   a_never_merge: assert property (o_bus.valid |-> !o_bus.mergeable)
      else $error("mergeable transfer issued");
   a_dev_share_nocache: assert property (o_bus.valid && o_bus.device
      |-> o_bus.shareable && !o_bus.cacheable && !o_bus.allocate)
      else $error("device transfer not shareable or cacheable");
   a_secure_mark: assert property (tk && i_security_ext && !i_sau_hit && i_req.secure_state
      && !i_req.is_fetch |=> o_bus.valid && !o_bus.nonsecure)
      else $error("secure address not marked secure");
   a_ns_mark: assert property (tk && i_security_ext && i_sau_hit && i_sau_attr == DMAD_ATTR_NONSECURE
      && i_fixed_attr == DMAD_ATTR_NONSECURE && !i_req.is_fetch |=> o_bus.valid && o_bus.nonsecure)
      else $error("non-secure address not marked non-secure");
   a_attr_sec_ns: assert property (tk && !i_security_ext |=> o_attr_sec == DMAD_ATTR_NONSECURE)
      else $error("address classified secure without security extension");
   a_bus_fields: assert property (tk && !i_security_ext && !i_req.is_fetch
      |=> o_bus.valid && o_bus.addr == $past(i_req.addr) && o_bus.is_write == $past(i_req.is_write))
      else $error("bus transfer does not carry the request");
   // ----------------------------------------
   // blocking, banks and faults
   // ----------------------------------------
   a_ns_block: assert property (tk && i_security_ext && !i_sau_hit && !i_req.secure_state
      |=> o_fault.security_violation && !o_bus.valid)
      else $error("non-secure access to secure address not blocked");
   a_data_bank: assert property (tk && i_security_ext && !i_req.is_fetch
      |=> o_mpu_bank_secure == $past(i_req.secure_state))
      else $error("data bank not from security state");
   a_fetch_bank: assert property (tk && i_security_ext && i_req.is_fetch && !i_sau_hit
      |=> o_mpu_bank_secure)
      else $error("fetch of secure address not on secure bank");
   a_xn_fetch: assert property (tk && !i_security_ext && i_req.is_fetch && i_req.addr[31:29] == 3'h7
      && !i_mpu_secure.hit && !i_mpu_nonsecure.hit |=> o_fault.mem_mgmt_fault && !o_bus.valid)
      else $error("execute-never fetch not faulted");
   a_gateway_src: assert property ($rose(o_fault.gateway_entry)
      |-> $past(i_req.is_fetch) && $past(i_req.secure_gateway_instr) && !$past(i_req.secure_state))
      else $error("gateway entry without gateway fetch");
   a_gateway_pass: assert property (tk && i_security_ext && i_req.is_fetch && i_req.secure_gateway_instr
      && !i_req.secure_state && i_sau_hit && i_sau_attr == DMAD_ATTR_NONSECURE_CALLABLE
      && i_fixed_attr != DMAD_ATTR_SECURE |=> o_fault.gateway_entry && !o_fault.security_violation)
      else $error("gateway fetch from non-secure-callable memory was blocked");
   // a stalled transfer must not change, or later ones could overtake it
   a_bus_hold: assert property (o_bus.valid && !(i_bus_ready && i_clk_en)
      |=> o_bus.valid && $stable(o_bus))
      else $error("stalled transfer changed");
endmodule : dmad_decoder_monitor

bind dmad_decoder dmad_decoder_monitor dmad_decoder_monitor_i (.i_clock, .i_rst, .i_clk_en, .i_req,
   .i_security_ext, .i_sau_hit, .i_sau_attr, .i_fixed_attr, .i_mpu_secure, .i_mpu_nonsecure,
   .i_bus_ready, .o_req_ready, .o_attr, .o_attr_sec, .o_mpu_bank_secure, .o_bus, .o_fault);

// *** tb/dmad_bus_peer.sv ***
// system bus side model: accepts at once, or after three stall cycles when slow
module dmad_bus_peer (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_slow,
   input dmad_pkg::dmad_bus_t i_bus,
   output logic o_bus_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   import dmad_pkg::*;
   // counts stalled edges of a pending transfer; ready rises once three have passed
   logic [1:0] wait_r;
   assign o_bus_ready = !i_slow || (wait_r == 2'h3);
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wait_r <= 2'h0;
      end else if (i_bus.valid && !o_bus_ready) begin
         wait_r <= wait_r + 2'h1;
      end else begin
         wait_r <= 2'h0;
      end
   end
endmodule : dmad_bus_peer

// *** tb/tb_top.sv ***
// self-checking bench for the default memory attribute decoder
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dmad_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_clk_en = 1'b1;
   logic i_security_ext = 1'b0;
   logic i_sau_hit = 1'b0;
   logic slow = 1'b0;
   dmad_req_t i_req = '0;
   dmad_sec_t i_sau_attr = DMAD_ATTR_NONSECURE;
   dmad_mpu_t i_mpu_nonsecure = '0;
   dmad_sec_t i_fixed_attr = DMAD_ATTR_NONSECURE;
   dmad_mpu_t i_mpu_secure = '0;
   logic i_bus_ready;
   logic o_req_ready;
   logic o_mpu_bank_secure;
   dmad_attr_t o_attr;
   dmad_bus_t o_bus;
   dmad_fault_t o_fault;
   int fails = 0;
   int n_compared = 0;
   logic [11:0] q[$];
   logic [31:0] lo[9] = '{32'h00000000, 32'h20000000, 32'h40000000, 32'h60000000, 32'hA0000000,
      32'hE0000000, 32'hE0040000, 32'hE0044000, 32'hE0100000};
   logic [31:0] hi[9] = '{32'h1FFFFFFF, 32'h3FFFFFFF, 32'h5FFFFFFF, 32'h9FFFFFFF, 32'hDFFFFFFF,
      32'hE003FFFF, 32'hE0043FFF, 32'hE00FFFFF, 32'hFFFFFFFF};
   initial begin
      forever #20 i_clock = ~i_clock;
   end
   dmad_decoder dmad_decoder_i (.i_clock, .i_rst, .i_clk_en, .i_req, .i_security_ext, .i_sau_hit,
      .i_sau_attr, .i_fixed_attr, .i_mpu_secure, .i_mpu_nonsecure, .i_bus_ready, .o_req_ready,
      .o_attr, .o_attr_sec(), .o_mpu_bank_secure, .o_bus, .o_fault);
   dmad_bus_peer dmad_bus_peer_i (.i_clock, .i_rst, .i_slow(slow), .i_bus(o_bus), .o_bus_ready(i_bus_ready));
   // ----------------------------------------
   // checking
   // ----------------------------------------
   task automatic stop_test;
      $display("mismatches %0d compared %0d", fails, n_compared);
      if (fails == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input logic [11:0] seen);
      logic [11:0] e;
      e = (q.size() != 0) ? q.pop_front() : 12'hFFF;
      n_compared++;
      if (e !== seen) begin
         fails++;
         $display("unexpected result: expected %h seen %h", e, seen);
      end
   endtask : chk
   // expected bus event: {0, region, device, early ack, shareable, non-secure}
   function automatic logic [11:0] bx(input int r, input logic ns);
      logic d;
      logic ea;
      d = r inside {2, 4, 5, 6, 7, 8};
      ea = r inside {2, 4, 8};
      return {4'h0, 4'(r), d, ea, d, ns};
   endfunction : bx
   always @(posedge i_clock) begin
      if (!i_rst && i_clk_en && o_bus.valid && i_bus_ready) begin
         chk({4'h0, o_attr.region, o_bus.device, o_bus.early_ack, o_bus.shareable, o_bus.nonsecure});
      end
      if (!i_rst && i_clk_en && o_fault != '0) begin
         chk({1'b1, o_fault, 8'h00});
      end
   end
   // ----------------------------------------
   // driving
   // ----------------------------------------
   // k = {fetch, secure state, gateway instr, security ext, attribution hit}
   task automatic send(input logic [31:0] a, input logic [4:0] k, input dmad_sec_t sa, input dmad_mpu_t m,
      input logic [11:0] e);
      int n;
      @(negedge i_clock);
      {i_req.is_fetch, i_req.secure_state, i_req.secure_gateway_instr, i_security_ext, i_sau_hit} = k;
      i_req.valid = 1'b1;
      i_req.addr = a;
      i_req.is_write = 1'($urandom);
      i_req.ordered = 1'($urandom);
      i_sau_attr = sa;
      i_mpu_nonsecure = m;
      i_clk_en = ($urandom % 4) != 0;
      for (n = 0; n < 40; n++) begin
         @(posedge i_clock);
         if (i_clk_en && o_req_ready) break;
         @(negedge i_clock);
         i_clk_en = 1'b1;
      end
      if (n == 40) begin
         fails++;
         stop_test();
      end
      q.push_back(e);
   endtask : send
   initial begin
      int r;
      int j;
      logic [31:0] a;
      void'($urandom(32'hEA61));
      repeat (16) @(posedge i_clock);
      @(negedge i_clock);
      i_rst = 1'b0;
      // region bases, region ends and random inner points, first prompt then with bus stalls
      for (j = 0; j < 6; j++) begin
         @(negedge i_clock);
         // drop the request so the idle edge does not take the last one twice
         i_req.valid = 1'b0;
         slow = j >= 3;
         for (r = 0; r < 9; r++) begin
            a = (j % 3 == 0) ? lo[r] : (j % 3 == 1) ? hi[r] : lo[r] + ($urandom % (hi[r] - lo[r] + 32'h1));
            send(a, {1'b0, 1'($urandom), 3'h0}, DMAD_ATTR_NONSECURE, '0, bx(r, 1'b1));
         end
      end
      @(negedge i_clock);
      i_req.valid = 1'b0;
      slow = 1'b0;
      send(32'h20000100, 5'b01010, DMAD_ATTR_NONSECURE, '0, bx(1, 1'b0));
      send(32'h20000100, 5'b01011, DMAD_ATTR_NONSECURE, '0, bx(1, 1'b1));
      send(32'h20000100, 5'b00010, DMAD_ATTR_NONSECURE, '0, {1'b1, 3'h4, 8'h00});
      send(32'h10000000, 5'b10111, DMAD_ATTR_NONSECURE_CALLABLE, '0, bx(0, 1'b0));
      q.push_back({1'b1, 3'h1, 8'h00});
      send(32'h10000000, 5'b10110, DMAD_ATTR_NONSECURE, '0, {1'b1, 3'h4, 8'h00});
      send(32'h00000200, 5'b11010, DMAD_ATTR_NONSECURE, '0, bx(0, 1'b0));
      send(32'hE0000000, 5'b10000, DMAD_ATTR_NONSECURE, '0, {1'b1, 3'h2, 8'h00});
      send(32'h40000000, 5'b10000, DMAD_ATTR_NONSECURE, '0, {1'b1, 3'h2, 8'h00});
      send(32'h20000000, 5'b00000, DMAD_ATTR_NONSECURE,
         dmad_mpu_t'{1'b1, DMAD_MEM_STRICT_DEVICE_ORDER, 1'b0, 1'b0, 1'b1}, {4'h0, 4'h1, 4'hB});
      // secure bank now holds a device region that only a wrong bank choice would pick up
      @(negedge i_clock);
      i_req.valid = 1'b0;
      i_mpu_secure = dmad_mpu_t'{1'b1, DMAD_MEM_DEVICE_EARLY_ACK, 1'b0, 1'b0, 1'b1};
      send(32'h00000300, 5'b11011, DMAD_ATTR_NONSECURE, '0, bx(0, 1'b1));
      @(negedge i_clock);
      i_req.valid = 1'b0;
      i_fixed_attr = DMAD_ATTR_SECURE;
      send(32'h20000100, 5'b01011, DMAD_ATTR_NONSECURE, '0, {4'h0, 4'h1, 4'hE});
      @(negedge i_clock);
      i_req.valid = 1'b0;
      repeat (20) @(posedge i_clock);
      n_compared++;
      if (q.size() != 0) begin
         fails++;
         $display("unexpected pending results: expected 0 seen %0d", q.size());
      end
      stop_test();
   end
endmodule : tb_top
